// ---- bench/testbench.sv ----
/*
  Register-level bench for the FIFO control and DMA request block.
  Assumes the far-side model supplies the shifter handshakes.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  i_core_clk = 1'b0;
  logic                  i_rst_n = 1'b0;
  logic                  awvalid = 1'b0;
  logic                  wvalid = 1'b0;
  logic                  arvalid = 1'b0;
  logic                  bready = 1'b0;
  logic                  rready = 1'b0;
  logic [7:0]            awaddr = 8'h00;
  logic [7:0]            araddr = 8'h00;
  logic [31:0]           wdata = 32'h0;
  logic [3:0]            wstrb = 4'hF;
  wire                   awready, wready, bvalid, arready, rvalid;
  wire [1:0]             bresp, rresp;
  wire [31:0]            rdata;
  wire                   tx_n, rx_n, fifo_on, irq, tx_take, rx_tmo;
  ufd_pkg::ufd_char_type tx_char, rx_char;
  logic [31:0]           v;
  logic [1:0]            last_resp;
  int                    bad_count = 0;
  int                    checks = 0;
  int                    cyc = 0;

  always #10 i_core_clk = ~i_core_clk;

  ufd_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_tx_char(tx_char),
    .i_tx_take(tx_take), .i_rx_char(rx_char), .i_rx_timeout(rx_tmo),
    .o_tx_dma_request_n(tx_n), .o_rx_dma_request_n(rx_n), .o_fifo_enabled(fifo_on),
    .o_irq(irq));

  ufd_far_model far (.i_core_clk(i_core_clk), .o_rx_char(rx_char), .o_tx_take(tx_take),
    .o_rx_timeout(rx_tmo));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  // Ready outputs are sampled at the edge, before that edge's updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge i_core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    last_resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge i_core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    last_resp = rresp;
  endtask

  // Control writes keep bits 5:4 at zero
  task automatic ctl(input logic [1:0] tx_holding_reg, input logic [3:0] low);
    wr(ufd_pkg::OFF_CTRL, {24'h0, tx_holding_reg, 2'b00, low});
  endtask

  task automatic look(input logic rx, input logic tx);
    repeat (2) @(posedge i_core_clk);
    #1;
    chk({30'h0, rx_n, tx_n}, {30'h0, rx, tx});
  endtask

  initial begin
    int thr_tab[4];
    thr_tab = '{1, 4, 8, 14};
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    look(1'b1, 1'b0);
    rd(ufd_pkg::OFF_CTRL, v);
    chk(v, 32'h0);
    rd(ufd_pkg::OFF_STATUS, v);
    chk({30'h0, v[7:6]}, 32'h0);
    // Disabled: holding registers of one character, interrupt path
    wr(ufd_pkg::OFF_INT_MASK, 32'h1);
    far.push(8'h3C);
    look(1'b0, 1'b0);
    chk({31'h0, irq}, 32'h1);
    rd(ufd_pkg::OFF_INT_STAT, v);
    chk({31'h0, v[0]}, 32'h1);
    look(1'b0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(ufd_pkg::OFF_RX_DATA, v);
    chk(v, 32'h3C);
    wr(ufd_pkg::OFF_INT_MASK, 32'h0);
    wr(ufd_pkg::OFF_TX_DATA, 32'h55);
    look(1'b1, 1'b1);
    chk({23'h0, tx_char}, {23'h0, 1'b1, 8'h55});
    far.pop();
    look(1'b1, 1'b0);
    ctl(2'h3, 4'hE);
    rd(ufd_pkg::OFF_CTRL, v);
    chk(v, 32'h0);
    // Enabled, single-character mode
    ctl(2'h0, 4'h1);
    rd(ufd_pkg::OFF_STATUS, v);
    chk({30'h0, v[7:6]}, 32'h3);
    chk({31'h0, fifo_on}, 32'h1);
    far.push(8'hA5);
    far.push(8'h5A);
    look(1'b0, 1'b0);
    rd(ufd_pkg::OFF_RX_DATA, v);
    chk(v, 32'hA5);
    look(1'b0, 1'b0);
    rd(ufd_pkg::OFF_RX_DATA, v);
    chk(v, 32'h5A);
    look(1'b1, 1'b0);
    wr(ufd_pkg::OFF_TX_DATA, 32'h11);
    look(1'b1, 1'b1);
    far.pop();
    look(1'b1, 1'b0);
    // Block mode: every threshold code, request held after one pop except at code 00
    for (int i = 0; i < 4; i++) begin
      ctl(2'(i), 4'hB);
      rd(ufd_pkg::OFF_CTRL, v);
      chk(v, {24'h0, 2'(i), 6'h09});
      for (int k = 1; k < thr_tab[i]; k++) far.push(8'(k));
      look(1'b1, 1'b0);
      far.push(8'hEE);
      look(1'b0, 1'b0);
      rd(ufd_pkg::OFF_STATUS, v);
      chk({27'h0, v[12:8]}, 32'(thr_tab[i]));
      rd(ufd_pkg::OFF_INT_STAT, v);
      chk({31'h0, v[0]}, 32'h1);
      rd(ufd_pkg::OFF_RX_DATA, v);
      look(i == 0, 1'b0);
    end
    // Keeps filling past the threshold up to the depth, then drains
    repeat (4) far.push(8'h77);
    rd(ufd_pkg::OFF_STATUS, v);
    chk({27'h0, v[12:8]}, 32'd16);
    rd(ufd_pkg::OFF_INT_STAT, v);
    chk({31'h0, v[3]}, 32'h1);
    repeat (15) rd(ufd_pkg::OFF_RX_DATA, v);
    look(1'b0, 1'b0);
    rd(ufd_pkg::OFF_RX_DATA, v);
    look(1'b1, 1'b0);
    far.push(8'h01);
    far.tmo();
    look(1'b0, 1'b0);
    ctl(2'h3, 4'hB);
    look(1'b1, 1'b0);
    // Block mode transmit: full queue releases the request
    repeat (15) wr(ufd_pkg::OFF_TX_DATA, 32'h42);
    look(1'b1, 1'b0);
    wr(ufd_pkg::OFF_TX_DATA, 32'h43);
    wr(ufd_pkg::OFF_TX_DATA, 32'h44);
    look(1'b1, 1'b1);
    rd(ufd_pkg::OFF_STATUS, v);
    chk({27'h0, v[20:16]}, 32'd16);
    rd(ufd_pkg::OFF_INT_STAT, v);
    rd(ufd_pkg::OFF_INT_STAT, v);
    chk({31'h0, v[1]}, 32'h0);
    far.pop();
    look(1'b1, 1'b0);
    rd(ufd_pkg::OFF_INT_STAT, v);
    chk({31'h0, v[1]}, 32'h1);
    ctl(2'h3, 4'hD);
    rd(ufd_pkg::OFF_STATUS, v);
    chk({27'h0, v[20:16]}, 32'h0);
    chk({31'h0, v[5]}, 32'h1);
    // A write with lane 0 strobed off leaves the control register alone
    wstrb <= 4'h0;
    wr(ufd_pkg::OFF_CTRL, 32'h0);
    wstrb <= 4'hF;
    chk({30'h0, last_resp}, {30'h0, ufd_pkg::RESP_OKAY});
    rd(ufd_pkg::OFF_CTRL, v);
    chk(v, 32'hC9);
    // Disabling empties a transmit queue that still holds a character
    wr(ufd_pkg::OFF_TX_DATA, 32'h66);
    ctl(2'h0, 4'h0);
    look(1'b1, 1'b0);
    chk({31'h0, fifo_on}, 32'h0);
    rd(ufd_pkg::OFF_STATUS, v);
    chk({30'h0, v[7:6]}, 32'h0);
    wr(8'h20, 32'h0);
    chk({30'h0, last_resp}, {30'h0, ufd_pkg::RESP_SLVERR});
    rd(8'h20, v);
    chk({30'h0, last_resp}, {30'h0, ufd_pkg::RESP_SLVERR});
    print_verdict();
  end
endmodule

`default_nettype wire

// ---- bench/ufd_far_model.sv ----
/*
  Far-side model of the shifters: the receiver pushes characters, the transmitter
  pops them and the receiver flags time-outs. Driven by task calls from the bench.
*/
`default_nettype none

module ufd_far_model (
  // Clock
  input  wire logic             i_core_clk,
  // Shifter side of the block
  output var ufd_pkg::ufd_char_type o_rx_char,
  output logic                      o_tx_take,
  output logic                      o_rx_timeout
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_rx_char = 9'h0FF;
    o_tx_take = 1'b0;
    o_rx_timeout = 1'b0;
  end

  // Outside a push the data lines show the inverse of the last byte
  task automatic push(input logic [7:0] d);
    @(posedge i_core_clk);
    o_rx_char <= {1'b1, d};
    @(posedge i_core_clk);
    o_rx_char <= {1'b0, ~d};
  endtask

  task automatic pop();
    @(posedge i_core_clk);
    o_tx_take <= 1'b1;
    @(posedge i_core_clk);
    o_tx_take <= 1'b0;
  endtask

  task automatic tmo();
    @(posedge i_core_clk);
    o_rx_timeout <= 1'b1;
    @(posedge i_core_clk);
    o_rx_timeout <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ---- rtl/ufd_pkg.sv ----
/*
  Shared constants, types and helpers for the UART FIFO control and DMA request block.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses in the low 8 address bits.
*/
`default_nettype none

package ufd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_TX_DATA  = 8'h04;
  localparam logic [7:0] OFF_RX_DATA  = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0C;
  localparam logic [7:0] OFF_INT_STAT = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;

  // fifo_control field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_RXCLR_BIT = 1;
  localparam int unsigned CTRL_TXCLR_BIT = 2;
  localparam int unsigned CTRL_DMA_BIT   = 3;
  localparam int unsigned CTRL_THR_LSB   = 6;

  // Status word field positions
  localparam int unsigned STAT_RXREQ_BIT = 4;
  localparam int unsigned STAT_TXREQ_BIT = 5;
  localparam int unsigned STAT_FIFO_LSB  = 6;
  localparam int unsigned STAT_RXCNT_LSB = 8;
  localparam int unsigned STAT_TXCNT_LSB = 16;
  localparam logic [1:0]  FIFO_ON_CODE   = 2'h3;

  // Interrupt status and mask bit positions
  localparam int unsigned IRQ_RX_BIT  = 0;
  localparam int unsigned IRQ_TX_BIT  = 1;
  localparam int unsigned IRQ_TMO_BIT = 2;
  localparam int unsigned IRQ_OVR_BIT = 3;
  localparam int unsigned IRQ_W       = 4;
  localparam logic [3:0]  INT_MASK_RST = 4'h0;

  // Receive fill thresholds for codes 00, 01, 10, 11
  localparam logic [4:0] THR_LVL_0 = 5'h01;
  localparam logic [4:0] THR_LVL_1 = 5'h04;
  localparam logic [4:0] THR_LVL_2 = 5'h08;
  localparam logic [4:0] THR_LVL_3 = 5'h0E;

  // Queue geometry
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CHAR_W     = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] tx_holding_reg;
    logic       dma_block;
    logic       enable;
  } ufd_ctrl_type;

  localparam ufd_ctrl_type CTRL_RST = '0;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } ufd_char_type;

  function automatic logic [4:0] rx_fill_level(input logic [1:0] code);
    logic [4:0] lvl;
    lvl = THR_LVL_0;
    unique case (code)
      2'h0: lvl = THR_LVL_0;
      2'h1: lvl = THR_LVL_1;
      2'h2: lvl = THR_LVL_2;
      2'h3: lvl = THR_LVL_3;
    endcase
    return lvl;
  endfunction

  function automatic logic reg_mapped(input logic [7:0] addr);
    return (addr == OFF_CTRL) || (addr == OFF_TX_DATA) || (addr == OFF_RX_DATA) ||
           (addr == OFF_STATUS) || (addr == OFF_INT_STAT) || (addr == OFF_INT_MASK);
  endfunction

endpackage

`default_nettype wire

// ---- rtl/ufd_top.sv ----
/*
  FIFO control, 16-entry transmit and receive queues and DMA request pins of a UART,
  with an AXI4-Lite register slave and a masked interrupt output.
  Assumes the transmit shifter pops characters with i_tx_take and the receive shifter
  pushes whole characters with i_rx_char; all inputs are synchronous to i_core_clk.
*/
// The AXI4-Lite register port and the register addresses were left to the implementer.
`default_nettype none

// How it works
// - In single-character mode, receive and transmit interrupts fire once per character.
// - With queues disabled, receive request goes low when the holding register loads.
// - Single-character mode or disabled: transmit request low while nothing waits to send.
// - Single-character mode: transmit request goes high once a character is written.
// - Single-character mode enabled: receive request low while any character is queued.
// - Block mode: transmit interrupt raised while the transmit queue has a free slot.
// - Block mode: transmit request high only when transmit queue is full.
// - Block mode: receive request goes low at threshold or on receive time-out.
// - Block mode: receive request returns high only once the receive queue is empty.
// - Block mode: receive interrupt when count equals threshold; queue keeps filling until full.
// - Threshold codes 00, 01, 10, 11 select 1, 4, 8 and 14 characters.
// - DMA mode bit resets to zero, single-character mode; one selects block mode.
// - Control bit 2 empties the transmit queue and reads back as zero.
// - Control bit 1 empties the receive queue and reads back as zero.
// - Control bit 0 enables both queues; reset leaves them disabled.
// - Writes with bit 0 clear ignore all other control bits.
// - Status bits 7:6 read as ones while queues are enabled, else zeros.
module ufd_top #(
  parameter int unsigned DEPTH = ufd_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_rst_n,
  // AXI4-Lite write address and data
  input  wire logic                i_s_axi_awvalid,
  output logic                     o_s_axi_awready,
  input  wire logic [7:0]          i_s_axi_awaddr,
  input  wire logic                i_s_axi_wvalid,
  output logic                     o_s_axi_wready,
  input  wire logic [31:0]         i_s_axi_wdata,
  input  wire logic [3:0]          i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic                     o_s_axi_bvalid,
  input  wire logic                i_s_axi_bready,
  output logic [1:0]               o_s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                i_s_axi_arvalid,
  output logic                     o_s_axi_arready,
  input  wire logic [7:0]          i_s_axi_araddr,
  output logic                     o_s_axi_rvalid,
  input  wire logic                i_s_axi_rready,
  output logic [31:0]              o_s_axi_rdata,
  output logic [1:0]               o_s_axi_rresp,
  // Transmit shifter side
  output ufd_pkg::ufd_char_type    o_tx_char,
  input  wire logic                i_tx_take,
  // Receive shifter side
  input  wire ufd_pkg::ufd_char_type i_rx_char,
  input  wire logic                i_rx_timeout,
  // DMA request pins and interrupt
  output logic                     o_tx_dma_request_n,
  output logic                     o_rx_dma_request_n,
  output logic                     o_fifo_enabled,
  output logic                     o_irq
);

  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam int unsigned PW = $clog2(DEPTH);

  ufd_pkg::ufd_ctrl_type          ctrl_r;
  logic [ufd_pkg::IRQ_W-1:0]      int_stat_r;
  logic [ufd_pkg::IRQ_W-1:0]      int_stat_nxt;
  logic [ufd_pkg::IRQ_W-1:0]      int_mask_r;
  logic [ufd_pkg::IRQ_W-1:0]      int_event;

  logic                           aw_got_r;
  logic                           w_got_r;
  logic [7:0]                     wr_addr_r;
  logic [31:0]                    wr_data_r;
  logic                           wr_strb0_r;
  logic                           bvalid_r;
  logic [1:0]                     bresp_r;
  logic                           rvalid_r;
  logic [31:0]                    rdata_r;
  logic [1:0]                     rresp_r;
  logic [31:0]                    rd_word;

  logic [ufd_pkg::CHAR_W-1:0]     tx_mem [DEPTH];
  logic [ufd_pkg::CHAR_W-1:0]     rx_mem [DEPTH];
  logic [PW-1:0]                  tx_wr_ptr_r;
  logic [PW-1:0]                  tx_rd_ptr_r;
  logic [PW-1:0]                  rx_wr_ptr_r;
  logic [PW-1:0]                  rx_rd_ptr_r;
  logic [CW-1:0]                  tx_count_r;
  logic [CW-1:0]                  rx_count_r;
  logic [CW-1:0]                  rx_count_nxt;
  logic [CW-1:0]                  cap;
  logic [CW-1:0]                  thr_lvl;
  logic                           rx_blk_req_r;

  logic wr_go;
  logic wr_ctrl;
  logic wr_tx;
  logic wr_mask;
  logic rd_go;
  logic rd_pop;
  logic int_clr;
  logic mode_chg;
  logic tx_clr;
  logic rx_clr;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_ovr;
  logic blk_mode;

  // Bus decode
  assign wr_go   = aw_got_r && w_got_r && !bvalid_r;
  assign wr_ctrl = wr_go && wr_strb0_r && (wr_addr_r == ufd_pkg::OFF_CTRL);
  assign wr_tx   = wr_go && wr_strb0_r && (wr_addr_r == ufd_pkg::OFF_TX_DATA);
  assign wr_mask = wr_go && wr_strb0_r && (wr_addr_r == ufd_pkg::OFF_INT_MASK);
  assign rd_go   = i_s_axi_arvalid && !rvalid_r;
  assign rd_pop  = rd_go && (i_s_axi_araddr == ufd_pkg::OFF_RX_DATA) && (rx_count_r != '0);
  assign int_clr = rd_go && (i_s_axi_araddr == ufd_pkg::OFF_INT_STAT);

  assign o_s_axi_awready = !aw_got_r && !bvalid_r;
  assign o_s_axi_wready  = !w_got_r && !bvalid_r;
  assign o_s_axi_bvalid  = bvalid_r;
  assign o_s_axi_bresp   = bresp_r;
  assign o_s_axi_arready = !rvalid_r;
  assign o_s_axi_rvalid  = rvalid_r;
  assign o_s_axi_rdata   = rdata_r;
  assign o_s_axi_rresp   = rresp_r;

  // Write channel capture and response
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got_r   <= 1'b0;
      w_got_r    <= 1'b0;
      wr_addr_r  <= 8'h00;
      wr_data_r  <= 32'h00000000;
      wr_strb0_r <= 1'b0;
      bvalid_r   <= 1'b0;
      bresp_r    <= ufd_pkg::RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_got_r  <= 1'b1;
        wr_addr_r <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_got_r    <= 1'b1;
        wr_data_r  <= i_s_axi_wdata;
        wr_strb0_r <= i_s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= ufd_pkg::reg_mapped(wr_addr_r) ? ufd_pkg::RESP_OKAY : ufd_pkg::RESP_SLVERR;
      end else if (bvalid_r && i_s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read data mux; clear bits of fifo_control always read as zero
  always_comb begin
    rd_word = 32'h00000000;
    unique case (i_s_axi_araddr)
      ufd_pkg::OFF_CTRL: begin
        rd_word[ufd_pkg::CTRL_EN_BIT]  = ctrl_r.enable;
        rd_word[ufd_pkg::CTRL_DMA_BIT] = ctrl_r.dma_block;
        rd_word[ufd_pkg::CTRL_THR_LSB +: 2] = ctrl_r.tx_holding_reg;
      end
      ufd_pkg::OFF_RX_DATA: begin
        if (rx_count_r != '0) begin
          rd_word[ufd_pkg::CHAR_W-1:0] = rx_mem[rx_rd_ptr_r];
        end
      end
      ufd_pkg::OFF_STATUS: begin
        rd_word[ufd_pkg::STAT_RXREQ_BIT] = !o_rx_dma_request_n;
        rd_word[ufd_pkg::STAT_TXREQ_BIT] = !o_tx_dma_request_n;
        rd_word[ufd_pkg::STAT_FIFO_LSB +: 2] = ctrl_r.enable ? ufd_pkg::FIFO_ON_CODE : 2'h0;
        rd_word[ufd_pkg::STAT_RXCNT_LSB +: CW] = rx_count_r;
        rd_word[ufd_pkg::STAT_TXCNT_LSB +: CW] = tx_count_r;
      end
      ufd_pkg::OFF_INT_STAT: rd_word[ufd_pkg::IRQ_W-1:0] = int_stat_r;
      ufd_pkg::OFF_INT_MASK: rd_word[ufd_pkg::IRQ_W-1:0] = int_mask_r;
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= ufd_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= ufd_pkg::reg_mapped(i_s_axi_araddr) ? ufd_pkg::RESP_OKAY : ufd_pkg::RESP_SLVERR;
    end else if (rvalid_r && i_s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // fifo_control register; bits 5:4 are never stored
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= ufd_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      if (wr_data_r[ufd_pkg::CTRL_EN_BIT]) begin
        ctrl_r.enable    <= 1'b1;
        ctrl_r.dma_block <= wr_data_r[ufd_pkg::CTRL_DMA_BIT];
        ctrl_r.tx_holding_reg       <= wr_data_r[ufd_pkg::CTRL_THR_LSB +: 2];
      end else begin
        ctrl_r.enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_mask_r <= ufd_pkg::INT_MASK_RST;
    end else if (wr_mask) begin
      int_mask_r <= wr_data_r[ufd_pkg::IRQ_W-1:0];
    end
  end

  // Queue control; switching the enable empties both queues
  assign blk_mode = ctrl_r.enable && ctrl_r.dma_block;
  assign cap      = ctrl_r.enable ? CW'(DEPTH) : CW'(1);
  assign thr_lvl  = CW'(ufd_pkg::rx_fill_level(ctrl_r.tx_holding_reg));
  assign mode_chg = wr_ctrl && (wr_data_r[ufd_pkg::CTRL_EN_BIT] != ctrl_r.enable);
  assign tx_clr   = mode_chg || (wr_ctrl && wr_data_r[ufd_pkg::CTRL_EN_BIT] &&
                                 wr_data_r[ufd_pkg::CTRL_TXCLR_BIT]);
  assign rx_clr   = mode_chg || (wr_ctrl && wr_data_r[ufd_pkg::CTRL_EN_BIT] &&
                                 wr_data_r[ufd_pkg::CTRL_RXCLR_BIT]);
  assign tx_push  = wr_tx && !tx_clr && (tx_count_r < cap);
  assign tx_pop   = i_tx_take && !tx_clr && (tx_count_r != '0);
  assign rx_push  = i_rx_char.valid && !rx_clr && ((rx_count_r < cap) || rd_pop);
  assign rx_ovr   = i_rx_char.valid && !rx_clr && !rx_push;
  assign rx_count_nxt = rx_clr ? '0 : CW'(rx_count_r + CW'(rx_push) - CW'(rd_pop));

  always_ff @(posedge i_core_clk) begin
    if (tx_push) begin
      tx_mem[tx_wr_ptr_r] <= wr_data_r[ufd_pkg::CHAR_W-1:0];
    end
    if (rx_push) begin
      rx_mem[rx_wr_ptr_r] <= i_rx_char.data;
    end
  end

  // Transmit queue; clearing leaves the shifter untouched
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_wr_ptr_r <= '0;
      tx_rd_ptr_r <= '0;
      tx_count_r  <= '0;
    end else if (tx_clr) begin
      tx_wr_ptr_r <= '0;
      tx_rd_ptr_r <= '0;
      tx_count_r  <= '0;
    end else begin
      if (tx_push) begin
        tx_wr_ptr_r <= PW'(tx_wr_ptr_r + 1'b1);
      end
      if (tx_pop) begin
        tx_rd_ptr_r <= PW'(tx_rd_ptr_r + 1'b1);
      end
      tx_count_r <= CW'(tx_count_r + CW'(tx_push) - CW'(tx_pop));
    end
  end

  // Receive queue
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_wr_ptr_r <= '0;
      rx_rd_ptr_r <= '0;
      rx_count_r  <= '0;
    end else if (rx_clr) begin
      rx_wr_ptr_r <= '0;
      rx_rd_ptr_r <= '0;
      rx_count_r  <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_ptr_r <= PW'(rx_wr_ptr_r + 1'b1);
      end
      if (rd_pop) begin
        rx_rd_ptr_r <= PW'(rx_rd_ptr_r + 1'b1);
      end
      rx_count_r <= rx_count_nxt;
    end
  end

  assign o_tx_char = {tx_count_r != '0, tx_mem[tx_rd_ptr_r]};

  // Block-mode receive request: set at threshold or time-out, held until empty
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_blk_req_r <= 1'b0;
    end else begin
      rx_blk_req_r <= blk_mode && (rx_count_nxt != '0) &&
                      (rx_blk_req_r || (rx_count_nxt >= thr_lvl) || i_rx_timeout);
    end
  end

  assign o_rx_dma_request_n = blk_mode ? !rx_blk_req_r : (rx_count_r == '0);
  assign o_tx_dma_request_n = blk_mode ? (tx_count_r == CW'(DEPTH))
                                       : (tx_count_r != '0);
  assign o_fifo_enabled     = ctrl_r.enable;

  // Interrupt events: per character in single mode, by level and threshold in block mode
  always_comb begin
    int_event = '0;
    if (blk_mode) begin
      int_event[ufd_pkg::IRQ_RX_BIT] = rx_push && (rx_count_nxt == thr_lvl);
      int_event[ufd_pkg::IRQ_TX_BIT] = tx_count_r != CW'(DEPTH);
    end else begin
      int_event[ufd_pkg::IRQ_RX_BIT] = rx_push;
      int_event[ufd_pkg::IRQ_TX_BIT] = tx_pop;
    end
    int_event[ufd_pkg::IRQ_TMO_BIT] = i_rx_timeout && (rx_count_r != '0);
    int_event[ufd_pkg::IRQ_OVR_BIT] = rx_ovr;
  end

  // Sticky status: a new event in the clearing read cycle survives
  assign int_stat_nxt = (int_clr ? '0 : int_stat_r) | int_event;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_stat_r <= '0;
    end else begin
      int_stat_r <= int_stat_nxt;
    end
  end

  assign o_irq = |(int_stat_r & int_mask_r);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  chk_tx_req_release: assert property (
    (!blk_mode && tx_push && tx_count_r == '0 && !tx_pop) |=> o_tx_dma_request_n)
    else $error("transmit request not released after first character");

  chk_tx_req_empty: assert property (
    (!blk_mode && !ctrl_r.enable && $past(tx_clr)) |-> !o_tx_dma_request_n)
    else $error("transmit request not active with empty holding register");

  chk_tx_req_full: assert property (
    blk_mode |-> (o_tx_dma_request_n == (tx_count_r == CW'(DEPTH))))
    else $error("block mode transmit request does not follow full");

  chk_rx_req_char: assert property (
    (!blk_mode && rx_push && !rx_clr && !wr_ctrl) |=> !o_rx_dma_request_n)
    else $error("receive request not active with a character queued");

  chk_rx_req_thresh: assert property (
    (blk_mode && rx_push && !rd_pop && !wr_ctrl && rx_count_nxt >= thr_lvl)
      |=> !o_rx_dma_request_n)
    else $error("block mode receive request missing at threshold");

  chk_rx_req_hold: assert property (
    (blk_mode && !o_rx_dma_request_n && rx_count_r > CW'(1) && !wr_ctrl)
      |=> !o_rx_dma_request_n)
    else $error("block mode receive request released before empty");

  chk_rx_thr_irq: assert property (
    (blk_mode && rx_push && rx_count_nxt == thr_lvl) |=> int_stat_r[ufd_pkg::IRQ_RX_BIT])
    else $error("threshold interrupt not raised");

  chk_thr_top_code: assert property (
    (ctrl_r.tx_holding_reg == 2'h3) |-> (thr_lvl == CW'(ufd_pkg::THR_LVL_3)))
    else $error("top threshold code does not select fourteen");

  chk_tx_clear_empty: assert property (
    (wr_ctrl && wr_data_r[ufd_pkg::CTRL_EN_BIT] && wr_data_r[ufd_pkg::CTRL_TXCLR_BIT])
      |=> (tx_count_r == '0) ##1
          (i_s_axi_araddr != ufd_pkg::OFF_CTRL || !rd_word[ufd_pkg::CTRL_TXCLR_BIT]))
    else $error("transmit clear did not empty the queue");

  chk_ctrl_ignore: assert property (
    (wr_ctrl && !wr_data_r[ufd_pkg::CTRL_EN_BIT])
      |=> (!ctrl_r.enable && $stable(ctrl_r.dma_block) && $stable(ctrl_r.tx_holding_reg)))
    else $error("control bits changed by a write with enable clear");

  chk_depth_bound: assert property (
    (rx_count_r <= CW'(DEPTH)) && (tx_count_r <= CW'(DEPTH)))
    else $error("queue count exceeds depth");

endmodule

`default_nettype wire
